// [verilog/dac_prog_regs.svh]
// register addresses, bit positions, reset values and counts of the converter
`ifndef DAC_PROG_REGS_SVH
`define DAC_PROG_REGS_SVH
`define DAC_ADDR_LEFT 2'h0
`define DAC_ADDR_RIGHT 2'h1
`define DAC_ADDR_PLAY 2'h2
`define DAC_ADDR_FMT 2'h3
`define DAC_SEL_HI 10
`define DAC_SEL_LO 9
`define DAC_LOAD_BIT 8
`define DAC_LEVEL_RESET 8'hff
`define DAC_PLAY_RESET 5'h00
`define DAC_FMT_RESET 9'h080
`define DAC_MUTE_BIT 0
`define DAC_DEEMPH_BIT 1
`define DAC_DISABLE_BIT 2
`define DAC_WLEN_LO_BIT 3
`define DAC_WLEN_HI_BIT 4
`define DAC_I2S_BIT 0
`define DAC_LRP_BIT 1
`define DAC_COMMON_BIT 2
`define DAC_ROLLOFF_BIT 3
`define DAC_INVERT_BIT 4
`define DAC_CLKDIV_BIT 5
`define DAC_RATE_LO_BIT 6
`define DAC_RATE_HI_BIT 7
`define DAC_ZD_BIT 8
`define DAC_ZERO_RUN 65536
`define DAC_OSR 64
`define DAC_OSR_LOG2 6
`endif

// [verilog/dac_pkg.sv]
// types of the converter program block; the modulator keeps its own state type
package dac_pkg;
	typedef enum logic [5:0] {
		FMT_RJ16 = 6'h01,
		FMT_RJ20 = 6'h02,
		FMT_RJ24 = 6'h04,
		FMT_LJ24 = 6'h08,
		FMT_I2S16 = 6'h10,
		FMT_I2S24 = 6'h20
	} word_fmt_t;
	typedef struct packed {
		logic cc_prev;
		logic latch_prev;
		logic bck_prev;
		logic wck_prev;
		logic xck_prev;
		logic half_clk;
		logic clk_out;
		logic [15:0] ctrl_shift;
		logic [7:0] left_level;
		logic [7:0] right_level;
		logic [7:0] left_applied;
		logic [7:0] right_applied;
		logic [4:0] play;
		logic [8:0] fmtc;
		logic [31:0] audio_sr;
		logic [5:0] bit_cnt;
		logic skip;
		logic [7:0] left_eff;
		logic [7:0] right_eff;
		logic [23:0] left_hold;
		logic [16:0] zero_run;
		logic zero_muted;
		logic [1:0][47:0] fifo;
		logic head;
		logic [1:0] cnt;
		logic overrun;
		logic [15:0] frame_cnt;
		logic [9:0] tick_period;
	} main_state_t;
endpackage : dac_pkg

// [verilog/dac_modulator.sv]
// eight-level fourth-order noise-shaping modulator for both channels
`timescale 1ns/100ps
`include "dac_prog_regs.svh"
module dac_modulator #(
	parameter int OSR = `DAC_OSR
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [9:0] i_tick_period,
	input wire logic i_valid,
	input wire logic [47:0] i_pair,
	output logic o_ready,
	output logic [2:0] o_code_left,
	output logic [2:0] o_code_right,
	output logic o_code_strobe
);
	typedef struct packed {
		logic [9:0] tick_cnt;
		logic [5:0] osr_cnt;
		logic [1:0][23:0] held;
		logic [1:0][3:0][23:0] err;
		logic [1:0][2:0] code;
		logic strobe;
	} mod_state_t;

	mod_state_t s_q;
	mod_state_t s_d;
	logic tick;

	if (OSR != 64)
		$error("modulator serves only 64 outputs per sample");

	// ==========================================================
	// quantiser step
	// ==========================================================
	// error feedback with four zeros at one half keeps eight levels out of overload
	function automatic logic [26:0] shape_step(input logic [23:0] x,
			input logic [3:0][23:0] e);
		logic signed [27:0] y;
		logic signed [27:0] q;
		logic signed [27:0] r;
		y = 28'(signed'(x)) + 28'(signed'(e[0])) * 28'sd2
			- ((28'(signed'(e[1])) * 28'sd3) >>> 1)
			+ (28'(signed'(e[2])) >>> 1) - (28'(signed'(e[3])) >>> 4);
		q = (y + 28'sd1048576) >>> 21;
		if (q > 28'sd3)
			q = 28'sd3;
		if (q < -28'sd4)
			q = -28'sd4;
		r = y - (q <<< 21);
		if (r > 28'sd4194303)
			r = 28'sd4194303;
		if (r < -28'sd4194304)
			r = -28'sd4194304;
		return {3'(q + 28'sd4), r[23:0]};
	endfunction : shape_step

	// ==========================================================
	// next state
	// ==========================================================
	always_comb
	begin
		logic [26:0] st;
		st = '0;
		s_d = s_q;
		s_d.strobe = 1'b0;
		tick = (s_q.tick_cnt == 10'h000);
		o_ready = tick && (s_q.osr_cnt == 6'(OSR - 1));
		if (tick)
		begin
			s_d.tick_cnt = (i_tick_period == 10'h000) ? 10'h000 : i_tick_period - 10'h001;
			s_d.osr_cnt = s_q.osr_cnt + 6'h01;
			s_d.strobe = 1'b1;
			for (int c = 0; c < 2; c++)
			begin
				st = shape_step(s_q.held[c], s_q.err[c]);
				s_d.code[c] = st[26:24];
				s_d.err[c] = {s_q.err[c][2:0], st[23:0]};
			end
		end
		else
			s_d.tick_cnt = s_q.tick_cnt - 10'h001;
		if (o_ready && i_valid)
			s_d.held = i_pair;
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_code_left = s_q.code[0];
	assign o_code_right = s_q.code[1];
	assign o_code_strobe = s_q.strobe;

	a_tick_pacing: assert property (@(posedge i_clk) disable iff (i_reset)
		s_q.strobe && i_tick_period == 10'h002 && $stable(i_tick_period)
		|=> !s_q.strobe ##1 s_q.strobe)
		else $error("modulator tick spacing wrong");
endmodule : dac_modulator

// [verilog/dac_program_block.sv]
// program registers, audio receiver and output control of the stereo converter
`timescale 1ns/100ps
`include "dac_prog_regs.svh"
module dac_program_block #(
	parameter int ZERO_RUN_CYCLES = `DAC_ZERO_RUN
) (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic I_CONTROL_CLOCK,
	input wire logic I_CONTROL_SERIAL_IN,
	input wire logic I_CONTROL_LATCH,
	input wire logic I_BIT_CLOCK_IN,
	input wire logic I_WORD_CLOCK_IN,
	input wire logic I_AUDIO_DATA_IN,
	input wire logic I_CRYSTAL_CLOCK_IN,
	output logic O_CLOCK_OUT,
	output logic [2:0] O_CODE_LEFT,
	output logic [2:0] O_CODE_RIGHT,
	output logic O_CODE_STROBE,
	output logic O_DEEMPH_ENABLE,
	output logic [1:0] O_DEEMPH_RATE,
	output logic O_ROLLOFF_SLOW,
	output logic O_ZERO_MUTE_ACTIVE,
	output logic O_OVERRUN
);
	dac_pkg::main_state_t s_q;
	dac_pkg::main_state_t s_d;
	logic wr_stb;
	logic [1:0] wr_addr;
	logic [15:0] wr_data;
	logic push;
	logic [23:0] push_right;
	logic bck_rise;
	logic mod_ready;
	logic pop;

	if (ZERO_RUN_CYCLES < 2 || ZERO_RUN_CYCLES > 131071)
		$error("zero run count out of range");

	// ==========================================================
	// helpers
	// ==========================================================
	// format decode
	function automatic dac_pkg::word_fmt_t fmt_decode(input logic [1:0] wl, input logic i2s);
		unique case ({wl, i2s})
			3'h0: return dac_pkg::FMT_RJ16;
			3'h2: return dac_pkg::FMT_RJ20;
			3'h4: return dac_pkg::FMT_RJ24;
			3'h6: return dac_pkg::FMT_LJ24;
			3'h1: return dac_pkg::FMT_I2S16;
			3'h3: return dac_pkg::FMT_I2S24;
			default: return dac_pkg::FMT_RJ16;
		endcase
	endfunction : fmt_decode

	function automatic logic [5:0] fmt_width(input dac_pkg::word_fmt_t f);
		unique case (f)
			dac_pkg::FMT_RJ16, dac_pkg::FMT_I2S16: return 6'd16;
			dac_pkg::FMT_RJ20: return 6'd20;
			default: return 6'd24;
		endcase
	endfunction : fmt_width

	function automatic logic [23:0] fmt_align(input logic [31:0] sr, input logic [5:0] w);
		unique case (w)
			6'd16: return {sr[15:0], 8'h00};
			6'd20: return {sr[19:0], 4'h0};
			default: return sr[23:0];
		endcase
	endfunction : fmt_align

	// half-decibel gain, twelve steps per halving
	function automatic logic [23:0] apply_gain(input logic [23:0] s, input logic [7:0] lvl);
		logic [7:0] idx;
		logic [4:0] sh;
		logic [15:0] m;
		logic signed [40:0] p;
		idx = 8'hff - lvl;
		sh = 5'(idx / 8'd12);
		unique case (4'(idx % 8'd12))
			4'h0: m = 16'hffff;
			4'h1: m = 16'hf1ae;
			4'h2: m = 16'he429;
			4'h3: m = 16'hd766;
			4'h4: m = 16'hcb59;
			4'h5: m = 16'hbff9;
			4'h6: m = 16'hb53c;
			4'h7: m = 16'hab19;
			4'h8: m = 16'ha186;
			4'h9: m = 16'h987d;
			4'ha: m = 16'h8ff6;
			default: m = 16'h87e8;
		endcase
		p = 41'(signed'(s)) * 41'(signed'({1'b0, m}));
		p = p >>> (6'd16 + 6'(sh));
		return (lvl == 8'h00) ? 24'h000000 : p[23:0];
	endfunction : apply_gain

	function automatic logic [23:0] negate_sat(input logic [23:0] s);
		return (s == 24'h800000) ? 24'h7fffff : 24'h000000 - s;
	endfunction : negate_sat

	function automatic logic [7:0] ramp(input logic [7:0] cur, input logic [7:0] tgt);
		if (cur < tgt)
			return cur + 8'h01;
		if (cur > tgt)
			return cur - 8'h01;
		return cur;
	endfunction : ramp

	// ==========================================================
	// next state
	// ==========================================================
	always_comb
	begin
		dac_pkg::word_fmt_t fmt;
		logic [5:0] width;
		logic is_left;
		logic rj;
		logic [23:0] smp;
		logic [7:0] tgt_r;
		logic [1:0] cnt_after;
		fmt = fmt_decode({s_q.play[`DAC_WLEN_HI_BIT], s_q.play[`DAC_WLEN_LO_BIT]},
			s_q.fmtc[`DAC_I2S_BIT]);
		width = fmt_width(fmt);
		rj = (fmt == dac_pkg::FMT_RJ16) || (fmt == dac_pkg::FMT_RJ20)
			|| (fmt == dac_pkg::FMT_RJ24);
		is_left = 1'b0;
		smp = '0;
		tgt_r = '0;
		cnt_after = '0;
		s_d = s_q;
		wr_stb = 1'b0;
		wr_addr = s_q.ctrl_shift[`DAC_SEL_HI:`DAC_SEL_LO];
		wr_data = s_q.ctrl_shift;
		push = 1'b0;
		push_right = '0;

		s_d.cc_prev = I_CONTROL_CLOCK;
		s_d.latch_prev = I_CONTROL_LATCH;
		if (I_CONTROL_CLOCK && !s_q.cc_prev)
			s_d.ctrl_shift = {s_q.ctrl_shift[14:0], I_CONTROL_SERIAL_IN};
		if (I_CONTROL_LATCH && !s_q.latch_prev)
		begin
			wr_stb = 1'b1;
			unique case (wr_addr)
				`DAC_ADDR_LEFT:
				begin
					s_d.left_level = wr_data[7:0];
					if (wr_data[`DAC_LOAD_BIT])
						s_d.left_applied = wr_data[7:0];
				end
				`DAC_ADDR_RIGHT:
				begin
					s_d.right_level = wr_data[7:0];
					if (wr_data[`DAC_LOAD_BIT])
						s_d.right_applied = wr_data[7:0];
				end
				`DAC_ADDR_PLAY: s_d.play = wr_data[4:0];
				default: s_d.fmtc = wr_data[8:0];
			endcase
		end

		s_d.xck_prev = I_CRYSTAL_CLOCK_IN;
		if (I_CRYSTAL_CLOCK_IN && !s_q.xck_prev)
			s_d.half_clk = !s_q.half_clk;
		s_d.clk_out = s_q.fmtc[`DAC_CLKDIV_BIT] ? s_d.half_clk : I_CRYSTAL_CLOCK_IN;

		// frame length sets the modulator tick
		s_d.frame_cnt = (s_q.frame_cnt == 16'hffff) ? s_q.frame_cnt : s_q.frame_cnt + 16'h0001;

		// audio receiver
		s_d.bck_prev = I_BIT_CLOCK_IN;
		s_d.wck_prev = I_WORD_CLOCK_IN;
		if (I_WORD_CLOCK_IN != s_q.wck_prev)
		begin
			is_left = s_q.wck_prev ^ s_q.fmtc[`DAC_LRP_BIT];
			smp = apply_gain(fmt_align(s_q.audio_sr, width),
				is_left ? s_q.left_eff : s_q.right_eff);
			if (s_q.fmtc[`DAC_INVERT_BIT])
				smp = negate_sat(smp);
			if (s_q.play[`DAC_DISABLE_BIT] || s_q.zero_muted)
				smp = '0;
			if (is_left)
				s_d.left_hold = smp;
			else
			begin
				push = 1'b1;
				push_right = smp;
			end
			s_d.audio_sr = '0;
			s_d.bit_cnt = '0;
			// interface format skips the first bit
			s_d.skip = s_q.fmtc[`DAC_I2S_BIT];
			if (!is_left)
			begin
				s_d.tick_period = 10'(({1'b0, s_q.frame_cnt} + 17'h00001) >> `DAC_OSR_LOG2);
				s_d.frame_cnt = '0;
				// soft mute and common level ramp
				tgt_r = s_q.fmtc[`DAC_COMMON_BIT] ? s_q.left_applied : s_q.right_applied;
				s_d.left_eff = ramp(s_q.left_eff,
					s_q.play[`DAC_MUTE_BIT] ? 8'h00 : s_q.left_applied);
				s_d.right_eff = ramp(s_q.right_eff,
					s_q.play[`DAC_MUTE_BIT] ? 8'h00 : tgt_r);
			end
		end
		if (bck_rise)
		begin
			if (s_d.skip)
				s_d.skip = 1'b0;
			else if (rj || s_d.bit_cnt < width)
			begin
				s_d.audio_sr = {s_d.audio_sr[30:0], I_AUDIO_DATA_IN};
				if (s_d.bit_cnt != 6'h3f)
					s_d.bit_cnt = s_d.bit_cnt + 6'h01;
			end
			if (I_AUDIO_DATA_IN)
			begin
				s_d.zero_run = '0;
				s_d.zero_muted = 1'b0;
			end
			else if (s_q.zero_run != 17'(ZERO_RUN_CYCLES))
				s_d.zero_run = s_q.zero_run + 17'h00001;
			if (s_d.zero_run == 17'(ZERO_RUN_CYCLES))
				s_d.zero_muted = 1'b1;
		end
		if (!s_q.fmtc[`DAC_ZD_BIT])
			s_d.zero_muted = 1'b0;

		// two-entry buffer towards the modulator
		pop = mod_ready && (s_q.cnt != 2'h0);
		cnt_after = s_q.cnt;
		if (pop)
		begin
			s_d.head = !s_q.head;
			cnt_after = s_q.cnt - 2'h1;
		end
		if (push)
		begin
			if (cnt_after == 2'h2)
				s_d.overrun = 1'b1;
			else
			begin
				s_d.fifo[s_d.head ^ cnt_after[0]] = {push_right, s_q.left_hold};
				cnt_after = cnt_after + 2'h1;
			end
		end
		s_d.cnt = cnt_after;
	end

	assign bck_rise = I_BIT_CLOCK_IN && !s_q.bck_prev;

	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			s_q <= '0;
			s_q.left_level <= `DAC_LEVEL_RESET;
			s_q.right_level <= `DAC_LEVEL_RESET;
			s_q.left_applied <= `DAC_LEVEL_RESET;
			s_q.right_applied <= `DAC_LEVEL_RESET;
			s_q.left_eff <= `DAC_LEVEL_RESET;
			s_q.right_eff <= `DAC_LEVEL_RESET;
			s_q.play <= `DAC_PLAY_RESET;
			s_q.fmtc <= `DAC_FMT_RESET;
		end
		else
			s_q <= s_d;
	end

	// ==========================================================
	// modulator and outputs
	// ==========================================================
	// sixty-four codes per sample
	dac_modulator #(
		.OSR(`DAC_OSR)
	) u_modulator (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.i_tick_period(s_q.tick_period),
		.i_valid(s_q.cnt != 2'h0),
		.i_pair(s_q.fifo[s_q.head]),
		.o_ready(mod_ready),
		.o_code_left(O_CODE_LEFT),
		.o_code_right(O_CODE_RIGHT),
		.o_code_strobe(O_CODE_STROBE)
	);

	assign O_CLOCK_OUT = s_q.clk_out;
	assign O_DEEMPH_ENABLE = s_q.play[`DAC_DEEMPH_BIT];
	assign O_DEEMPH_RATE = {s_q.fmtc[`DAC_RATE_HI_BIT], s_q.fmtc[`DAC_RATE_LO_BIT]};
	assign O_ROLLOFF_SLOW = s_q.fmtc[`DAC_ROLLOFF_BIT];
	assign O_ZERO_MUTE_ACTIVE = s_q.zero_muted;
	assign O_OVERRUN = s_q.overrun;

	// ==========================================================
	// checks
	// ==========================================================
	a_left_defer: assert property (@(posedge I_CLK) disable iff (I_RESET)
		wr_stb && wr_addr == `DAC_ADDR_LEFT && !wr_data[`DAC_LOAD_BIT]
		|=> $stable(s_q.left_applied) && s_q.left_level == $past(wr_data[7:0]))
		else $error("left level applied without load bit");
	a_left_apply: assert property (@(posedge I_CLK) disable iff (I_RESET)
		wr_stb && wr_addr == `DAC_ADDR_LEFT && wr_data[`DAC_LOAD_BIT]
		|=> s_q.left_applied == $past(wr_data[7:0]))
		else $error("left level not applied");
	a_right_apply: assert property (@(posedge I_CLK) disable iff (I_RESET)
		wr_stb && wr_addr == `DAC_ADDR_RIGHT && wr_data[`DAC_LOAD_BIT]
		|=> s_q.right_applied == $past(wr_data[7:0]) && $stable(s_q.left_applied))
		else $error("right level not applied");
	a_play_write: assert property (@(posedge I_CLK) disable iff (I_RESET)
		wr_stb && wr_addr == `DAC_ADDR_PLAY
		|=> O_DEEMPH_ENABLE == $past(wr_data[`DAC_DEEMPH_BIT]))
		else $error("playback control not written");
	a_disable_zero: assert property (@(posedge I_CLK) disable iff (I_RESET)
		push && s_q.play[`DAC_DISABLE_BIT] |-> push_right == 24'h000000)
		else $error("disabled output not zero");
	a_zero_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!s_q.fmtc[`DAC_ZD_BIT] |=> !O_ZERO_MUTE_ACTIVE)
		else $error("zero mute while detection off");
	a_zero_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
		s_q.fmtc[`DAC_ZD_BIT] && bck_rise && !I_AUDIO_DATA_IN
		&& s_q.zero_run == 17'(ZERO_RUN_CYCLES - 1) |=> O_ZERO_MUTE_ACTIVE)
		else $error("zero mute not set");
	a_zero_release: assert property (@(posedge I_CLK) disable iff (I_RESET)
		bck_rise && I_AUDIO_DATA_IN |=> !O_ZERO_MUTE_ACTIVE && s_q.zero_run == 17'h00000)
		else $error("zero run not restarted");
	a_clk_buffer: assert property (@(posedge I_CLK) disable iff (I_RESET)
		!s_q.fmtc[`DAC_CLKDIV_BIT] && !s_d.fmtc[`DAC_CLKDIV_BIT]
		|=> O_CLOCK_OUT == $past(I_CRYSTAL_CLOCK_IN))
		else $error("clock output not buffered");
	a_common_level: assert property (@(posedge I_CLK) disable iff (I_RESET)
		push && s_q.fmtc[`DAC_COMMON_BIT] && !s_q.play[`DAC_MUTE_BIT]
		&& s_q.right_eff == s_q.left_applied |=> s_q.right_eff == $past(s_q.left_applied))
		else $error("common level not followed");
endmodule : dac_program_block

// [verification/dac_host_model.sv]
// host model that writes control words over the three-wire serial port
`timescale 1ns/100ps
module dac_host_model (
	input wire logic i_clk,
	output logic o_control_clock,
	output logic o_control_serial_in,
	output logic o_control_latch
);
	initial
	begin
		o_control_clock = 1'b0;
		o_control_serial_in = 1'b0;
		o_control_latch = 1'b0;
	end
	// each pin level stands for two system clocks
	task automatic hold(input logic c, input logic d, input logic l);
		@(negedge i_clk);
		o_control_clock = c;
		o_control_serial_in = d;
		o_control_latch = l;
		@(negedge i_clk);
	endtask : hold
	task automatic send_word(input logic [1:0] sel, input logic [8:0] payload,
		input int extra, input logic [3:0] junk);
		logic [15:0] w;
		// reserved upper bits always sent low
		w = {5'h00, sel, payload};
		// leading junk bits must be pushed out by the real word
		for (int k = 0; k < extra; k++)
		begin
			hold(1'b0, junk[k], 1'b0);
			hold(1'b1, junk[k], 1'b0);
		end
		// sixteen bits msb first, then a latch pulse
		for (int i = 15; i >= 0; i--)
		begin
			hold(1'b0, w[i], 1'b0);
			hold(1'b1, w[i], 1'b0);
		end
		// data line no longer meaningful, so show the inverse
		hold(1'b0, ~w[0], 1'b1);
		hold(1'b0, ~w[0], 1'b0);
	endtask : send_word
endmodule : dac_host_model

// [verification/testbench.sv]
// self-checking bench of the converter program block
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] cyc = 7'h00;
	logic bit_clk = 1'b0;
	logic word_clk = 1'b1;
	logic audio_bit = 1'b0;
	logic xtal = 1'b0;
	logic [15:0] lv = 16'h0000;
	logic [15:0] rv = 16'h0000;
	wire cclk;
	wire cdata;
	wire clatch;
	logic clk_out;
	logic [2:0] code_l;
	logic [2:0] code_r;
	logic strobe;
	logic deemph_en;
	logic [1:0] deemph_rate;
	logic rolloff;
	logic zmute;
	logic overrun;
	logic acc = 1'b0;
	logic [8:0] p2;
	logic [8:0] p3;
	int sl;
	int sr;
	int n;
	int dl;
	int dr;
	int d0;
	int e;
	int span;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	dac_host_model host (.i_clk(clk), .o_control_clock(cclk),
		.o_control_serial_in(cdata), .o_control_latch(clatch));
	dac_program_block #(.ZERO_RUN_CYCLES(16)) uut (.I_CLK(clk), .I_RESET(rst),
		.I_CONTROL_CLOCK(cclk), .I_CONTROL_SERIAL_IN(cdata), .I_CONTROL_LATCH(clatch),
		.I_BIT_CLOCK_IN(bit_clk), .I_WORD_CLOCK_IN(word_clk), .I_AUDIO_DATA_IN(audio_bit),
		.I_CRYSTAL_CLOCK_IN(xtal), .O_CLOCK_OUT(clk_out), .O_CODE_LEFT(code_l),
		.O_CODE_RIGHT(code_r), .O_CODE_STROBE(strobe), .O_DEEMPH_ENABLE(deemph_en),
		.O_DEEMPH_RATE(deemph_rate), .O_ROLLOFF_SLOW(rolloff), .O_ZERO_MUTE_ACTIVE(zmute),
		.O_OVERRUN(overrun));
	// ==========================================================
	// audio source: 16 bits a phase, 4 clocks a bit, word clock high first
	always @(negedge clk)
	begin
		cyc <= cyc + 7'h01;
		xtal <= cyc[1];
		bit_clk <= cyc[1];
		word_clk <= ~cyc[6];
		audio_bit <= cyc[6] ? rv[~cyc[5:2]] : lv[~cyc[5:2]];
	end
	always @(negedge clk)
	begin
		if (acc && strobe === 1'b1 && n < 64)
		begin
			sl += code_l;
			sr += code_r;
			n++;
		end
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			failures++;
			results();
		end
	end
	// ==========================================================
	// helpers
	task automatic results;
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	function automatic logic near0(input int d);
		return d >= -8 && d <= 8;
	endfunction : near0
	task automatic wr(input logic [1:0] sel, input logic [8:0] p);
		host.send_word(sel, p, $urandom_range(4, 0), 4'($urandom));
	endtask : wr
	task automatic frames(input int f);
		repeat (f * 128) @(posedge clk);
	endtask : frames
	// code sums over 64 strobes, minus the mid code
	task automatic measure;
		repeat (640) @(posedge clk);
		sl = 0;
		sr = 0;
		n = 0;
		acc = 1'b1;
		for (span = 0; span < 2000 && n < 64; span++) @(posedge clk);
		acc = 1'b0;
		`CHECK("strobe_count", 64, n)
		`CHECK("code_rate", 1'b1, span >= 120 && span <= 136)
		dl = sl - 256;
		dr = sr - 256;
	endtask : measure
	task automatic count_edges;
		logic prev;
		e = 0;
		@(negedge clk);
		prev = clk_out;
		repeat (64)
		begin
			@(negedge clk);
			if (clk_out !== prev) e++;
			prev = clk_out;
		end
	endtask : count_edges
	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'hf87fa448));
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		`CHECK("rate_reset", 2'b10, deemph_rate)
		`CHECK("deemph_reset", 1'b0, deemph_en)
		`CHECK("rolloff_reset", 1'b0, rolloff)
		for (int i = 0; i < 8; i++)
		begin
			p2 = 9'($urandom) & 9'h01e;
			p3 = 9'($urandom) & 9'h0ff;
			if (p3[7:6] == 2'b00) p3[7:6] = 2'b11;
			if (p3[0]) p2[4] = 1'b0;
			wr(2'h2, p2);
			wr(2'h3, p3);
			wr(2'($urandom_range(1, 0)), 9'($urandom) & 9'h0ff);
			`CHECK("deemph_en", p2[1], deemph_en)
			`CHECK("deemph_rate", p3[7:6], deemph_rate)
			`CHECK("rolloff", p3[3], rolloff)
		end
		wr(2'h3, 9'h080);
		count_edges();
		`CHECK("clkout_full", 1'b1, e >= 30 && e <= 34)
		wr(2'h3, 9'h0a0);
		count_edges();
		`CHECK("clkout_half", 1'b1, e >= 14 && e <= 18)
		wr(2'h2, 9'h000);
		wr(2'h3, 9'h080);
		lv = 16'h4000;
		measure();
		d0 = dl;
		`CHECK("left_pos", 1'b1, dl > 16)
		`CHECK("right_zero", 1'b1, near0(dr))
		wr(2'h3, 9'h082);
		measure();
		`CHECK("swap_left", 1'b1, near0(dl))
		`CHECK("swap_right", 1'b1, dr > 16)
		wr(2'h3, 9'h090);
		measure();
		`CHECK("invert_left", 1'b1, dl < -16)
		wr(2'h3, 9'h080);
		wr(2'h2, 9'h004);
		measure();
		`CHECK("disable_left", 1'b1, near0(dl))
		wr(2'h2, 9'h000);
		wr(2'h0, 9'h0f0);
		frames(24);
		measure();
		`CHECK("left_deferred", 1'b1, dl * 4 > d0 * 3)
		wr(2'h0, 9'h1f0);
		frames(24);
		measure();
		`CHECK("left_applied", 1'b1, dl * 4 < d0 * 3 && dl > 4)
		rv = 16'h4000;
		wr(2'h3, 9'h084);
		frames(24);
		measure();
		`CHECK("common_right", 1'b1, dr * 4 < d0 * 3)
		wr(2'h3, 9'h080);
		wr(2'h1, 9'h0f0);
		frames(24);
		measure();
		`CHECK("right_deferred", 1'b1, dr * 4 > d0 * 3)
		wr(2'h1, 9'h1f0);
		frames(24);
		measure();
		`CHECK("right_applied", 1'b1, dr * 4 < d0 * 3)
		wr(2'h0, 9'h100);
		wr(2'h2, 9'h001);
		frames(250);
		measure();
		`CHECK("level_mute", 1'b1, near0(dl))
		`CHECK("soft_mute", 1'b1, near0(dr))
		wr(2'h2, 9'h000);
		lv = 16'h0000;
		rv = 16'h0000;
		repeat (160) @(posedge clk);
		`CHECK("zd_off", 1'b0, zmute)
		wr(2'h3, 9'h180);
		for (int k = 0; k < 400 && zmute !== 1'b1; k++) @(posedge clk);
		`CHECK("zd_on", 1'b1, zmute)
		lv = 16'h8000;
		for (int k = 0; k < 300 && zmute !== 1'b0; k++) @(posedge clk);
		`CHECK("zd_release", 1'b0, zmute)
		`CHECK("overrun", 1'b0, overrun)
		results();
	end
endmodule : testbench
